/* rtl/modulo_table_defs.svh */
// Offsets, field positions, reset values and vector addresses of the address block
`ifndef MODULO_TABLE_DEFS_SVH
`define MODULO_TABLE_DEFS_SVH
`define OFS_MODCTRL      8'h00
`define OFS_XSTART       8'h04
`define OFS_XEND         8'h08
`define OFS_YSTART       8'h0c
`define OFS_YEND         8'h10
`define OFS_TBLPAGE      8'h14
`define OFS_STATUS       8'h18
`define XSEL_LSB         0
`define YSEL_LSB         4
`define YEN_BIT          14
`define XEN_BIT          15
`define SEL_OFF          4'hf
`define RST_MODCTRL      16'h00ff
`define RST_BOUND        16'h0000
`define RST_TBLPAGE      8'h00
`define CFG_PAGE_BIT     7
`define RESET_VECTOR     24'h000000
`define START_ADDR_WORD  24'h000002
`define IVT_PRI_START    24'h000004
`define IVT_PRI_END      24'h0000ff
`define IVT_ALT_START    24'h000100
`define IVT_ALT_END      24'h0001ff
`define VECTOR_LIMIT     24'h000200
`define MAX_BUF_WORDS    17'h08000
`endif

/* rtl/modulo_table_pkg.sv */
// Types shared by the modulo and table access block
package modulo_table_pkg;
    typedef struct packed {
        logic        valid;
        logic        isY;
        logic [3:0]  regSel;
        logic [15:0] addr;
        logic        decrement;
        logic        byteOp;
    } agu_req_t;
    typedef enum logic [1:0] {
        TBL_READ_LOW, TBL_READ_HIGH, TBL_WRITE_LOW, TBL_WRITE_HIGH
    } tbl_op_t;
    typedef struct packed {
        logic        valid;
        tbl_op_t     op;
        logic        byteMode;
        logic [15:0] offset;
        logic [15:0] wdata;
    } tbl_req_t;
    typedef enum {ST_RESET_FETCH, ST_VECTOR_FETCH, ST_RUN} boot_state_t;
endpackage

/* rtl/modulo_table_access.sv */
// Modulo address generation, program address sequencing and table access mapping
//
// Decided for this implementation: the address map and register access over Wishbone.
`timescale 1ns/1ps
`include "modulo_table_defs.svh"

// Summary of operation
// - Program location is low word at even address, upper word at odd; top byte absent.
// - Program address stays even and steps by two up or down.
// - Addresses below 0x000200 are reserved vectors, flagged when code runs there.
// - After reset fetch at 0x000000; word at 0x000002 gives application start.
// - Primary vector table 0x000004-0x0000FF, alternate 0x000100-0x0001FF, one entry per source.
// - One circular buffer in X space and one in Y space; X may address program.
// - Power-of-two buffers check both bounds; others too, except no decrement wrap for one ending at 0xFFFF; none ending at 0xFFFF wraps on increment.
// - Four 16-bit boundary registers hold X and Y start and end addresses.
// - Y modulo calculations clear the least significant address bit.
// - Length follows from end minus start plus one; at most 32K words, except that a full 0x0000-0xFFFF X buffer also passes the length check.
// - X modulo active only when select is not 15 and bit 15 set.
// - Y modulo active only when select is not 15 and bit 14 set.
// - Low-word word read returns program bits 15:0.
// - Low-word byte read returns upper byte when select is 1, else lower.
// - High-word word read returns bits 23:16 low, zero in bits 15:8.
// - High-word byte read returns zero for phantom byte, else bits 23:16.
// - Only high-word table read and write reach program bits 23:16.
// - Table page from page register; bit 7 selects configuration space.
module modulo_table_access
    import modulo_table_pkg::*;
#(
    parameter int VECTOR_SOURCES = 8
) (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire agu_req_t    aguReq,
    output logic      [15:0] aguAddrOut,
    output logic      [15:0] aguNextPtr,
    output logic             aguWrapped,
    output logic             aguValid,
    input  wire logic        pcAdvance,
    input  wire logic        pcDown,
    input  wire logic        pcLoad,
    input  wire logic [23:0] pcLoadAddr,
    input  wire logic        irqTake,
    input  wire logic        irqAltTable,
    input  wire logic [$clog2(VECTOR_SOURCES)-1:0] irqSource,
    output logic      [23:0] progAddr,
    output logic             progFetch,
    input  wire logic [23:0] progData,
    output logic             inVectorArea,
    input  wire tbl_req_t    tblReq,
    output logic      [23:0] tblProgAddr,
    output logic             tblConfigSpace,
    output logic             tblWriteLow,
    output logic             tblWriteHigh,
    output logic      [15:0] tblWriteData,
    output logic      [15:0] tblReadData,
    output logic             tblValid
);
    logic        rstSync1;
    logic        rstSync2;
    logic [15:0] modCtrl;
    logic [15:0] xStart;
    logic [15:0] xEnd;
    logic [15:0] yStart;
    logic [15:0] yEnd;
    logic [7:0]  tblPage;
    boot_state_t bootState;
    logic [23:0] pc;
    logic        xActive;
    logic        yActive;
    logic [15:0] bufStart;
    logic [15:0] bufEnd;
    logic [15:0] effAddr;
    logic [16:0] bufLen;
    logic        powTwo;
    logic        modActive;
    logic [15:0] stepAddr;
    logic [15:0] next_ptr;
    logic        next_wrap;
    logic        wbHit;
    logic [15:0] lowWord;
    logic [7:0]  highByte;
    logic [15:0] next_rdata;
    logic [31:0] next_wbData;

    // Reset release synchroniser
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk or negedge rstSync2) begin
        if (!rstSync2) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wbHit;
        end
    end

    // Boundary and control registers, byte-lane writes
    always_ff @(posedge clk or negedge rstSync2) begin
        if (!rstSync2) begin
            modCtrl <= `RST_MODCTRL;
            xStart  <= `RST_BOUND;
            xEnd    <= `RST_BOUND;
            yStart  <= `RST_BOUND;
            yEnd    <= `RST_BOUND;
            tblPage <= `RST_TBLPAGE;
        end else if (wbHit && wb_we_i) begin
            unique case (wb_adr_i)
                `OFS_MODCTRL: begin
                    if (wb_sel_i[0]) modCtrl[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) modCtrl[15:8] <= wb_dat_i[15:8];
                end
                `OFS_XSTART: begin
                    if (wb_sel_i[0]) xStart[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) xStart[15:8] <= wb_dat_i[15:8];
                end
                `OFS_XEND: begin
                    if (wb_sel_i[0]) xEnd[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) xEnd[15:8] <= wb_dat_i[15:8];
                end
                `OFS_YSTART: begin
                    if (wb_sel_i[0]) yStart[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) yStart[15:8] <= wb_dat_i[15:8];
                end
                `OFS_YEND: begin
                    if (wb_sel_i[0]) yEnd[7:0] <= wb_dat_i[7:0];
                    if (wb_sel_i[1]) yEnd[15:8] <= wb_dat_i[15:8];
                end
                `OFS_TBLPAGE: begin
                    if (wb_sel_i[0]) tblPage <= wb_dat_i[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_wbData = 32'h00000000;
        unique case (wb_adr_i)
            `OFS_MODCTRL: next_wbData = {16'h0000, modCtrl};
            `OFS_XSTART:  next_wbData = {16'h0000, xStart};
            `OFS_XEND:    next_wbData = {16'h0000, xEnd};
            `OFS_YSTART:  next_wbData = {16'h0000, yStart};
            `OFS_YEND:    next_wbData = {16'h0000, yEnd};
            `OFS_TBLPAGE: next_wbData = {24'h000000, tblPage};
            `OFS_STATUS:  next_wbData = {28'h0000000, inVectorArea, yActive, xActive, powTwo};
            default:      next_wbData = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge rstSync2) begin
        if (!rstSync2) begin
            wb_dat_o <= 32'h00000000;
        end else if (wbHit && !wb_we_i) begin
            wb_dat_o <= next_wbData;
        end
    end

    // One buffer per space; frame and stack pointers left to software
    assign xActive = (modCtrl[`XSEL_LSB+:4] != `SEL_OFF) && modCtrl[`XEN_BIT];
    assign yActive = (modCtrl[`YSEL_LSB+:4] != `SEL_OFF) && modCtrl[`YEN_BIT];

    always_comb begin
        bufStart  = aguReq.isY ? yStart : xStart;
        bufEnd    = aguReq.isY ? yEnd : xEnd;
        effAddr   = aguReq.isY ? {aguReq.addr[15:1], 1'b0} : aguReq.addr;
        if (aguReq.isY) begin
            bufStart = {bufStart[15:1], 1'b0};
            bufEnd   = {bufEnd[15:1], 1'b0};
        end
        bufLen    = 17'({1'b0, bufEnd} - {1'b0, bufStart}) + 17'd1;
        powTwo    = (bufLen & (bufLen - 17'd1)) == 17'd0;
        modActive = (aguReq.isY ? (yActive && aguReq.regSel == modCtrl[`YSEL_LSB+:4])
                                : (xActive && aguReq.regSel == modCtrl[`XSEL_LSB+:4]))
                    && ({1'b0, bufLen[15:0]} <= `MAX_BUF_WORDS) && (bufEnd >= bufStart);
        stepAddr  = aguReq.byteOp && !aguReq.isY ? 16'd1 : 16'd2;
        next_ptr  = aguReq.decrement ? 16'(effAddr - stepAddr) : 16'(effAddr + stepAddr);
        next_wrap = 1'b0;
        if (modActive) begin
            if (!aguReq.decrement && effAddr >= bufStart && next_ptr > bufEnd) begin
                next_ptr  = bufStart;
                next_wrap = 1'b1;
            end else if (aguReq.decrement && effAddr <= bufEnd
                         && (next_ptr < bufStart || effAddr < stepAddr)
                         && (powTwo || !(effAddr >= bufStart && bufEnd == 16'hffff))) begin
                next_ptr  = powTwo ? 16'(bufEnd - (stepAddr - 16'd1)) : bufEnd;
                next_wrap = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rstSync2) begin
        if (!rstSync2) begin
            aguAddrOut <= 16'h0000;
            aguNextPtr <= 16'h0000;
            aguWrapped <= 1'b0;
            aguValid   <= 1'b0;
        end else begin
            aguValid <= aguReq.valid;
            if (aguReq.valid) begin
                aguAddrOut <= effAddr;
                aguNextPtr <= next_ptr;
                aguWrapped <= next_wrap;
            end
        end
    end

    // Boot sequencing and program counter
    always_ff @(posedge clk or negedge rstSync2) begin
        if (!rstSync2) begin
            bootState <= ST_RESET_FETCH;
            pc        <= `RESET_VECTOR;
        end else begin
            unique case (bootState)
                ST_RESET_FETCH: begin
                    bootState <= ST_VECTOR_FETCH;
                    pc        <= `START_ADDR_WORD;
                end
                ST_VECTOR_FETCH: begin
                    bootState <= ST_RUN;
                    pc        <= {progData[23:1], 1'b0};
                end
                ST_RUN: begin
                    if (irqTake) begin
                        pc <= (irqAltTable ? `IVT_ALT_START : `IVT_PRI_START)
                              + {23'(irqSource), 1'b0};
                    end else if (pcLoad) begin
                        pc <= {pcLoadAddr[23:1], 1'b0};
                    end else if (pcAdvance) begin
                        pc <= pcDown ? 24'(pc - 24'd2) : 24'(pc + 24'd2);
                    end
                end
            endcase
        end
    end

    assign progAddr  = pc;
    assign progFetch = rstSync2;

    always_ff @(posedge clk or negedge rstSync2) begin
        if (!rstSync2) begin
            inVectorArea <= 1'b0;
        end else begin
            inVectorArea <= (bootState == ST_RUN) && (pc < `VECTOR_LIMIT);
        end
    end

    // Table access mapping
    assign tblProgAddr    = {tblPage, tblReq.offset[15:1], 1'b0};
    assign tblConfigSpace = tblPage[`CFG_PAGE_BIT];
    assign lowWord        = progData[15:0];
    assign highByte       = progData[23:16];

    always_comb begin
        next_rdata = 16'h0000;
        unique case (tblReq.op)
            TBL_READ_LOW: begin
                if (!tblReq.byteMode) begin
                    next_rdata = lowWord;
                end else begin
                    next_rdata = {8'h00, tblReq.offset[0] ? lowWord[15:8] : lowWord[7:0]};
                end
            end
            TBL_READ_HIGH: begin
                if (tblReq.byteMode && tblReq.offset[0]) begin
                    next_rdata = 16'h0000;
                end else begin
                    next_rdata = {8'h00, highByte};
                end
            end
            TBL_WRITE_LOW, TBL_WRITE_HIGH: next_rdata = 16'h0000;
        endcase
    end

    always_ff @(posedge clk or negedge rstSync2) begin
        if (!rstSync2) begin
            tblReadData  <= 16'h0000;
            tblValid     <= 1'b0;
            tblWriteLow  <= 1'b0;
            tblWriteHigh <= 1'b0;
            tblWriteData <= 16'h0000;
        end else begin
            tblValid     <= tblReq.valid;
            tblWriteLow  <= tblReq.valid && tblReq.op == TBL_WRITE_LOW;
            tblWriteHigh <= tblReq.valid && tblReq.op == TBL_WRITE_HIGH;
            if (tblReq.valid) begin
                tblReadData <= next_rdata;
                if (tblReq.op == TBL_WRITE_HIGH) begin
                    tblWriteData <= {8'h00, tblReq.wdata[7:0]};
                end else begin
                    tblWriteData <= tblReq.wdata;
                end
            end
        end
    end
endmodule

/* testbench/modulo_table_access_assertions.sv */
// Port assertions for the modulo and table access block
`timescale 1ns/1ps
module modulo_table_checker
    import modulo_table_pkg::*;
#(
    parameter int VECTOR_SOURCES = 8
) (
    input wire logic        clk,
    input wire logic        rstn,
    input wire agu_req_t    aguReq,
    input wire logic [15:0] aguAddrOut,
    input wire logic        aguValid,
    input wire logic        pcAdvance,
    input wire logic        pcDown,
    input wire logic        pcLoad,
    input wire logic        irqTake,
    input wire logic        irqAltTable,
    input wire logic [$clog2(VECTOR_SOURCES)-1:0] irqSource,
    input wire logic [23:0] progAddr,
    input wire logic [23:0] progData,
    input wire tbl_req_t    tblReq,
    input wire logic [23:0] tblProgAddr,
    input wire logic        tblConfigSpace,
    input wire logic        tblWriteLow,
    input wire logic        tblWriteHigh,
    input wire logic [15:0] tblReadData,
    input wire logic        tblValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_pc_even: assert property (progAddr[0] == 1'b0)
        else $error("program address odd");
    chk_pc_step: assert property (pcAdvance && !pcLoad && !irqTake && progAddr >= 24'h000200 |=>
        progAddr == ($past(pcDown) ? $past(progAddr) - 24'h2 : $past(progAddr) + 24'h2))
        else $error("program address step wrong");
    chk_irq_vector: assert property (irqTake && progAddr >= 24'h000200 |=>
        progAddr == ($past(irqAltTable) ? 24'h000100 : 24'h000004) + 24'($past(irqSource)) * 24'h2)
        else $error("vector address wrong");
    chk_tbl_addr: assert property (tblReq.valid |->
        tblProgAddr[15:0] == {tblReq.offset[15:1], 1'b0} && tblConfigSpace == tblProgAddr[23])
        else $error("table address wrong");
    chk_read_low: assert property (tblReq.valid && tblReq.op == TBL_READ_LOW && !tblReq.byteMode |=>
        tblValid && tblReadData == $past(progData[15:0]))
        else $error("low word read wrong");
    chk_read_high: assert property (tblReq.valid && tblReq.op == TBL_READ_HIGH &&
        !(tblReq.byteMode && !tblReq.offset[0]) |=>
        tblValid && tblReadData == ($past(tblReq.byteMode) ? 16'h0000 : {8'h00, $past(progData[23:16])}))
        else $error("high word read wrong");
    chk_write_high: assert property (tblReq.valid && tblReq.op == TBL_WRITE_HIGH |=>
        tblWriteHigh && !tblWriteLow)
        else $error("high write strobe wrong");
    chk_y_lsb: assert property (aguReq.valid && aguReq.isY |=> aguValid && aguAddrOut[0] == 1'b0)
        else $error("y address lsb set");
endmodule
bind modulo_table_access modulo_table_checker #(.VECTOR_SOURCES(VECTOR_SOURCES)) chk_u (.*);

/* testbench/program_memory_model.sv */
// Program memory model answering fetches and table reads
`timescale 1ns/1ps
module program_memory_model
    import modulo_table_pkg::*;
(
    input  wire tbl_req_t    tblReq,
    input  wire logic [23:0] progAddr,
    input  wire logic [23:0] tblProgAddr,
    output logic      [23:0] progData
);
    // Address pattern; word at 0x000002 holds the start address
    function automatic logic [23:0] word(input logic [23:0] a);
        return {a[7:0] ^ a[23:16] ^ 8'h3c, a[15:0] ^ 16'ha55a};
    endfunction
    assign progData = tblReq.valid ? word(tblProgAddr) : word(progAddr);
endmodule

/* testbench/testbench.sv */
// Self-checking bench for the modulo and table access block
`timescale 1ns/1ps
`include "modulo_table_defs.svh"
module testbench;
    import modulo_table_pkg::*;
    logic        clk, rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]  wb_adr_i, pg;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    agu_req_t    aguReq;
    tbl_req_t    tblReq, r;
    logic [15:0] aguAddrOut, aguNextPtr, tblWriteData, tblReadData, xs, xe, ys, ye;
    logic        aguWrapped, aguValid, pcAdvance, pcDown, pcLoad, irqTake, irqAltTable, progFetch;
    logic        inVectorArea, tblConfigSpace, tblWriteLow, tblWriteHigh, tblValid;
    logic [2:0]  irqSource;
    logic [23:0] pcLoadAddr, progAddr, progData, tblProgAddr, w;
    int          miscompares, comparisons, cycles, n, seed;

    modulo_table_access dut_u (.*);
    program_memory_model mem_u (.*);

    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (miscompares == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h3;
        wb_dat_i <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 40);
        if (n >= 40) begin
            $display("wrong value wb_ack_o expected 1 seen %b", wb_ack_o);
            miscompares++;
        end
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk);
    endtask

    function automatic logic [16:0] mod_next(logic [15:0] a, logic d, logic [15:0] s, logic [15:0] e, logic on);
        logic [15:0] nx;
        nx = d ? a - 16'h2 : a + 16'h2;
        if (on && !d && a <= e && nx > e)
            return {1'b1, s};
        if (on && d && a >= s && nx < s)
            return {1'b1, (((e - s + 16'h1) & (e - s)) == 16'h0) ? e - 16'h1 : e};
        return {1'b0, nx};
    endfunction

    task automatic address_generator(input logic y, input logic [3:0] sel, input logic [15:0] a, input logic d, input logic on);
        logic [15:0] ea;
        ea = y ? {a[15:1], 1'b0} : a;
        aguReq <= '{1'b1, y, sel, a, d, 1'b0};
        @(posedge clk);
        aguReq.valid <= 1'b0;
        @(posedge clk);
        check("aguAddrOut", ea, aguAddrOut);
        check("aguNextPtr", mod_next(ea, d, y ? ys : xs, y ? ye : xe, on), {aguWrapped, aguNextPtr});
    endtask

    task automatic rand_agu(input logic xon, input logic yon);
        logic       y;
        logic [3:0] sel;
        y = 1'($urandom);
        sel = ($urandom_range(0, 3) == 0) ? 4'h9 : (y ? (yon ? 4'h5 : 4'hf) : 4'h3);
        address_generator(y, sel, y ? ys + 16'($urandom_range(0, 31)) : xs + 16'($urandom_range(0, 7) * 2),
            1'($urandom), (y ? yon : xon) && sel != 4'h9);
    endtask

    function automatic logic [15:0] exp_read(tbl_req_t t, logic [23:0] p);
        if (t.op == TBL_READ_LOW)
            return (t.byteMode && t.offset[0]) ? {8'h00, p[15:8]} : p[15:0];
        return (t.byteMode && t.offset[0]) ? 16'h0000 : {8'h00, p[23:16]};
    endfunction

    task automatic tbl(input tbl_req_t t, input logic [7:0] page);
        logic [23:0] a;
        logic        rd;
        logic [15:0] m;
        a = {page, t.offset[15:1], 1'b0};
        rd = t.op inside {TBL_READ_LOW, TBL_READ_HIGH};
        // Reads mask the byte lane; a high write carries only the upper program byte
        if (rd)
            m = t.byteMode ? 16'h00ff : 16'hffff;
        else
            m = (t.op == TBL_WRITE_HIGH) ? 16'h00ff : 16'hffff;
        tblReq <= t;
        @(posedge clk);
        check("tblProgAddr", a, tblProgAddr);
        check("tblConfigSpace", page[7], tblConfigSpace);
        tblReq.valid <= 1'b0;
        @(posedge clk);
        if (rd)
            check("tblReadData", exp_read(t, mem_u.word(a)) & m, tblReadData & m);
        else
            check("tblWrite", {t.op == TBL_WRITE_HIGH, t.op == TBL_WRITE_LOW, t.wdata & m},
                {tblWriteHigh, tblWriteLow, tblWriteData});
    endtask

    initial begin
        clk = 1'b0;
        {rstn, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, aguReq, tblReq} = '0;
        {pcAdvance, pcDown, pcLoad, pcLoadAddr, irqTake, irqAltTable, irqSource} = '0;
        seed = $urandom(32'h09ff);
        repeat (16) @(posedge clk);
        check("progAddr", 24'h0, progAddr);
        rstn <= 1'b1;
        n = 0;
        while (progAddr !== 24'h2 && n < 20) begin
            @(posedge clk);
            n++;
        end
        @(posedge clk);
        w = mem_u.word(24'h2);
        check("progAddr", {w[23:1], 1'b0}, progAddr);
        wb(1'b0, `OFS_MODCTRL, '0);
        check("modctrl", 32'h00ff, q);
        wb(1'b0, 8'h1c, '0);
        check("unmapped", 32'h0, q);
        xs = 16'h1000;
        xe = 16'h100f;
        ys = 16'h3000;
        ye = 16'h301f;
        wb(1'b1, `OFS_XSTART, {16'h0, xs});
        wb(1'b1, `OFS_XEND, {16'h0, xe});
        wb(1'b1, `OFS_YSTART, {16'h0, ys});
        wb(1'b1, `OFS_YEND, {16'h0, ye});
        wb(1'b0, `OFS_YEND, '0);
        check("yend", {16'h0, ye}, q);
        wb(1'b1, `OFS_MODCTRL, 32'hc053);
        repeat (32) rand_agu(1'b1, 1'b1);
        wb(1'b1, `OFS_MODCTRL, 32'h40f3);
        repeat (16) rand_agu(1'b0, 1'b0);
        wb(1'b1, `OFS_MODCTRL, 32'hc053);
        xe = 16'h1009;
        wb(1'b1, `OFS_XEND, {16'h0, xe});
        address_generator(1'b0, 4'h3, 16'h1008, 1'b0, 1'b1);
        repeat (24) begin
            pg = 8'($urandom);
            wb(1'b1, `OFS_TBLPAGE, {24'h0, pg});
            r = '{1'b1, tbl_op_t'($urandom_range(0, 3)), 1'($urandom), 16'($urandom), 16'($urandom)};
            tbl(r, pg);
        end
        repeat (300) begin
            @(posedge clk);
            pcAdvance <= 1'($urandom);
            pcDown <= 1'($urandom);
            pcLoad <= ($urandom_range(0, 7) == 0);
            pcLoadAddr <= {8'h01, 16'($urandom) & 16'hfffe};
            irqTake <= ($urandom_range(0, 15) == 0);
            irqAltTable <= 1'($urandom);
            irqSource <= 3'($urandom);
        end
        @(posedge clk);
        pcAdvance <= 1'b0;
        pcLoad <= 1'b0;
        irqTake <= 1'b1;
        irqAltTable <= 1'b1;
        irqSource <= 3'h5;
        @(posedge clk);
        irqTake <= 1'b0;
        @(posedge clk);
        check("progAddr", 24'h00010a, progAddr);
        wb(1'b0, `OFS_STATUS, '0);
        check("inVectorArea", 32'h8, q & 32'h8);
        finish_test();
    end
endmodule
